// *** pll_clk_params.svh ***
// Offsets, field positions, reset values and counts for the clock generator
`ifndef PLL_CLK_PARAMS_SVH
`define PLL_CLK_PARAMS_SVH

// Register port widths
`define ADDR_W         3
`define DATA_W         8

// Register offsets on the link register port
`define OFS_CONTROL    3'h0
`define OFS_MULT_HIGH  3'h2
`define OFS_MULT_LOW   3'h3
`define OFS_RANGE      3'h4
`define OFS_DIVIDER    3'h5

// Field positions in the control register
`define BIT_PLL_POWER_ON      5
`define BIT_BCS        4
`define PRE_HI         3
`define PRE_LO         2
`define VPR_HI         1
`define VPR_LO         0

// Reset values; the loop is on at reset so it can settle
`define RST_CONTROL    8'h20
`define RST_MULT_HIGH  8'h00
`define RST_MULT_LOW   8'h40
`define RST_RANGE      8'h40
`define RST_DIVIDER    8'h01

// Multiplier high part width, divider field width
`define MULT_HIGH_W    4
`define DIV_W          4

// Source edges to wait on each side during a changeover
`define XFER_TICKS     2'h3

// Range exponent code that software must never write
`define VPR_FORBIDDEN  2'h3

`endif

// *** pll_clk_pkg.sv ***
// Types used by the clock generator end of the link
package pll_clk_pkg;

	// Which source feeds the output stage
	typedef enum logic {
		SEL_XTAL,
		SEL_VCO
	} src_type;

	// Changeover sequencer states
	typedef enum logic {
		ST_RUN,
		ST_SWITCH
	} xfer_state_type;

endpackage : pll_clk_pkg

// *** pll_link_if.sv ***
// Link between the clock generator and the system integration side
`timescale 1ns/1ps
`include "pll_clk_params.svh"

interface pll_link_if;

	// Register port
	logic [`ADDR_W-1:0] reg_addr;
	logic [`DATA_W-1:0] reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [`DATA_W-1:0] reg_rdata;
	// Base clock, as a level sampled on clk
	logic               base_clock_out;

	// Clock generator end
	modport device (
		input  reg_addr,
		input  reg_wdata,
		input  reg_wr,
		input  reg_rd,
		output reg_rdata,
		output base_clock_out
	);

	// System integration end
	modport host (
		output reg_addr,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		input  reg_rdata,
		input  base_clock_out
	);

endinterface : pll_link_if

// *** tick_counter.sv ***
// Counts source edges during a changeover, saturating at the wait count
`timescale 1ns/1ps
`include "pll_clk_params.svh"

module tick_counter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Control
	input  wire logic clear,
	input  wire logic tick,
	// Status
	output logic      done
);

	logic [1:0] count_reg; // Edges seen so far

	// Count edges, hold at the limit, restart on clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= 2'h0;
		end else if (clear) begin
			count_reg <= 2'h0;
		end else if (tick && !done) begin
			count_reg <= count_reg + 2'h1;
		end
	end

	assign done = (count_reg == `XFER_TICKS);

endmodule : tick_counter

// *** clock_generator.sv ***
// Clock generator digital side: PLL programming and base clock selector
//
// What this block and the software driving it do
// R1: Zero divider or multiplier behaves as one
// R2: Zero linear range disables PLL, forces crystal
// R3: Changeover waits three crystal, three VCO edges
// R4: Output held still during changeover
// R5: Output divides selected source by two
// R6: VCO cannot be selected while PLL off
// R7: PLL cannot switch off while VCO selected
// R8: PLL on/off and select need separate writes
// R9: Software never writes range exponent three
// R10: Software picks range exponent by VCO band
// R11: Software steps prescaler only when multiplier overflows
// R12: VCO ratio is two-power prescale times multiplier over divider
// R13: Centre frequency is linear times two-power range
// R14: Software writes each field into its register
// R15: Software normally uses 32.768 kHz, divider one
// R16: Select bit picks VCO when set, reset clears
// R17: Programming fields read-only while PLL on
// R18: Select forced clear when PLL off or range zero
// R19: Divider toggles only after changeover, starts low
`timescale 1ns/1ps
`include "pll_clk_params.svh"

module clock_generator
	import pll_clk_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Link to the system integration side
	pll_link_if.device       link,
	// Source clock edges, one-cycle pulses on clk
	input  wire logic        xtal_tick,
	input  wire logic        vco_tick,
	// Settings for the analog loop
	output logic             pll_enable,
	output logic [1:0]       prescale_exp,
	output logic [11:0]      mult_eff,
	output logic [3:0]       divider_eff,
	output logic [14:0]      vco_ratio_num,
	output logic [1:0]       range_exp,
	output logic [7:0]       linear_range,
	output logic [10:0]      vco_center_code,
	// Selector status
	output logic             switching,
	output logic             vco_active
);

	// Programming registers
	logic [7:0]           control_reg;     // Power, select, prescale, range exponent
	logic [7:0]           control_next;    // Control value after this cycle's write
	logic [7:0]           mult_high_reg;   // Multiplier upper part
	logic [7:0]           mult_low_reg;    // Multiplier lower part
	logic [7:0]           range_reg;       // Linear range factor
	logic [7:0]           divider_reg;     // Reference divider
	logic [`DATA_W-1:0]   rdata_reg;       // Read data, one cycle after strobe

	// Decoded control
	logic                 pll_on;          // Power bit
	logic                 sel_vco;         // Base clock select bit
	logic                 range_zero;      // Linear range programmed to zero
	logic                 wr_control;      // Write to control register
	logic                 prog_open;       // Programming registers writable

	// Selector state
	xfer_state_type       state_reg;       // Changeover sequencer
	src_type              active_reg;      // Source currently driving output
	src_type              wanted;          // Source asked for by select bit
	logic                 base_out_reg;    // Divide-by-two output stage
	logic                 vco_live;        // VCO edges, only while loop runs
	logic                 src_tick;        // Edge of the active source
	logic [1:0]           src_ticks;       // Edges per counter
	logic [1:0]           src_done;        // Counter reached wait count

	assign pll_on     = control_reg[`BIT_PLL_POWER_ON];
	assign sel_vco    = control_reg[`BIT_BCS];
	assign range_zero = (range_reg == 8'h00);
	assign wr_control = link.reg_wr && (link.reg_addr == `OFS_CONTROL);
	// Loop registers lock once the loop is powered
	assign prog_open  = !pll_on; // R17

	// Loop powered only with a usable range factor
	assign pll_enable = pll_on && !range_zero; // R2

	// Control register next value with the power/select interlocks
	always_comb begin
		control_next = control_reg;
		if (wr_control) begin
			// Power cannot drop while the select bit picks the VCO
			control_next[`BIT_PLL_POWER_ON] = sel_vco ? 1'b1 : link.reg_wdata[`BIT_PLL_POWER_ON]; // R7
			// Select may only follow an already-running loop
			if (pll_on && !range_zero) begin
				control_next[`BIT_BCS] = link.reg_wdata[`BIT_BCS]; // R6
			end else begin
				control_next[`BIT_BCS] = 1'b0; // R6
			end
			// A write that flips power leaves select alone
			if (control_next[`BIT_PLL_POWER_ON] != pll_on) begin
				control_next[`BIT_BCS] = sel_vco; // R8
			end
			// Prescale and range exponent frozen while powered
			if (prog_open) begin
				control_next[`PRE_HI:`PRE_LO] = link.reg_wdata[`PRE_HI:`PRE_LO]; // R17
				control_next[`VPR_HI:`VPR_LO] = link.reg_wdata[`VPR_HI:`VPR_LO]; // R17
			end
		end
		// Select cannot stand without power and range
		if (!control_next[`BIT_PLL_POWER_ON] || range_zero) begin
			control_next[`BIT_BCS] = 1'b0; // R18
		end
	end

	// Control register; reset leaves power on and select clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			control_reg <= `RST_CONTROL; // R16
		end else begin
			control_reg <= control_next;
		end
	end

	// Loop programming registers, ignored writes while powered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mult_high_reg <= `RST_MULT_HIGH;
			mult_low_reg  <= `RST_MULT_LOW;
			range_reg     <= `RST_RANGE;
			divider_reg   <= `RST_DIVIDER;
		end else if (link.reg_wr && prog_open) begin // R17
			if (link.reg_addr == `OFS_MULT_HIGH) begin
				// Only the low nibble is implemented
				mult_high_reg <= {4'h0, link.reg_wdata[`MULT_HIGH_W-1:0]};
			end else if (link.reg_addr == `OFS_MULT_LOW) begin
				mult_low_reg <= link.reg_wdata;
			end else if (link.reg_addr == `OFS_RANGE) begin
				range_reg <= link.reg_wdata;
			end else if (link.reg_addr == `OFS_DIVIDER) begin
				divider_reg <= {4'h0, link.reg_wdata[`DIV_W-1:0]};
			end
		end
	end

	// Read port; unmapped offsets read zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
		end else if (link.reg_rd) begin
			if (link.reg_addr == `OFS_CONTROL) begin
				rdata_reg <= control_reg;
			end else if (link.reg_addr == `OFS_MULT_HIGH) begin
				rdata_reg <= mult_high_reg;
			end else if (link.reg_addr == `OFS_MULT_LOW) begin
				rdata_reg <= mult_low_reg;
			end else if (link.reg_addr == `OFS_RANGE) begin
				rdata_reg <= range_reg;
			end else if (link.reg_addr == `OFS_DIVIDER) begin
				rdata_reg <= divider_reg;
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	assign link.reg_rdata = rdata_reg;

	// Settings for the analog loop, registered so they never glitch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale_exp    <= 2'h0;
			mult_eff        <= 12'h001;
			divider_eff     <= 4'h1;
			vco_ratio_num   <= 15'h0001;
			range_exp       <= 2'h0;
			linear_range    <= 8'h00;
			vco_center_code <= 11'h000;
		end else begin
			prescale_exp <= control_reg[`PRE_HI:`PRE_LO];
			range_exp    <= control_reg[`VPR_HI:`VPR_LO];
			linear_range <= range_reg;
			// Zero multiplier or divider would stall the loop
			if ({mult_high_reg[3:0], mult_low_reg} == 12'h000) begin
				mult_eff <= 12'h001; // R1
			end else begin
				mult_eff <= {mult_high_reg[3:0], mult_low_reg};
			end
			if (divider_reg[3:0] == 4'h0) begin
				divider_eff <= 4'h1; // R1
			end else begin
				divider_eff <= divider_reg[3:0];
			end
			// Feedback ratio numerator; loop divides it by divider_eff
			vco_ratio_num <= 15'(mult_eff) << control_reg[`PRE_HI:`PRE_LO]; // R12
			// Centre of range in steps of the nominal frequency
			vco_center_code <= 11'(range_reg) << control_reg[`VPR_HI:`VPR_LO]; // R13
		end
	end

	// VCO edges ignored while the loop is off or disabled
	assign vco_live = vco_tick && pll_enable; // R2
	assign wanted   = sel_vco ? SEL_VCO : SEL_XTAL; // R16
	assign src_tick = (active_reg == SEL_VCO) ? vco_live : xtal_tick;

	// Crystal counter at index 0, VCO counter at index 1
	assign src_ticks = {vco_live, xtal_tick};

	// One edge counter per source for the changeover wait
	for (genvar g = 0; g < 2; g++) begin : g_wait
		tick_counter u_wait (
			.clk   (clk),
			.rst_b (rst_b),
			.clear (state_reg == ST_RUN),
			.tick  (src_ticks[g]),
			.done  (src_done[g])
		);
	end

	// Changeover sequencer; new source only after both sides settle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg  <= ST_RUN;
			active_reg <= SEL_XTAL;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (wanted != active_reg) begin
						state_reg <= ST_SWITCH;
					end
				end
				ST_SWITCH: begin
					// Three edges of each source seen
					if (src_done == 2'b11) begin // R3
						active_reg <= wanted;
						state_reg  <= ST_RUN;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	// Output stage; frozen while a changeover is pending
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			base_out_reg <= 1'b0; // R19
		end else if (state_reg == ST_RUN && wanted == active_reg && src_tick) begin // R4
			base_out_reg <= !base_out_reg; // R5
		end
	end

	assign link.base_clock_out = base_out_reg;
	assign switching           = (state_reg == ST_SWITCH) || (wanted != active_reg);
	assign vco_active          = (active_reg == SEL_VCO);

endmodule : clock_generator

// *** system_integration.sv ***
// System integration end: forwards register commands, derives the bus clock
`timescale 1ns/1ps
`include "pll_clk_params.svh"

module system_integration (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// Link to the clock generator
	pll_link_if.host                link,
	// Software register port
	input  wire logic [`ADDR_W-1:0] cmd_addr,
	input  wire logic [`DATA_W-1:0] cmd_wdata,
	input  wire logic               cmd_wr,
	input  wire logic               cmd_rd,
	output logic      [`DATA_W-1:0] cmd_rdata,
	output logic                    cmd_refused,
	// Derived bus clock
	output logic                    bus_clock,
	output logic                    bus_tick
);

	logic bad_range;      // Control write carrying the forbidden exponent
	logic base_prev_reg;  // Base clock one cycle ago
	logic base_rise;      // Rising edge of base clock
	logic refused_reg;    // Refusal pulse
	logic bus_clock_reg;  // Bus clock level
	logic bus_tick_reg;   // Bus clock rising edge pulse

	// Forbidden range exponent never reaches the device
	assign bad_range = cmd_wr && (cmd_addr == `OFS_CONTROL) &&
		(cmd_wdata[`VPR_HI:`VPR_LO] == `VPR_FORBIDDEN); // R9

	// Field values pass unchanged; band, prescale and crystal choice stay with software
	assign link.reg_addr  = cmd_addr;  // R14
	assign link.reg_wdata = cmd_wdata; // R10 R11 R15
	assign link.reg_wr    = cmd_wr && !bad_range;
	assign link.reg_rd    = cmd_rd;
	assign cmd_rdata      = link.reg_rdata;

	assign base_rise = link.base_clock_out && !base_prev_reg;

	// Refusal pulse, and halving of the base clock into the bus clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			refused_reg   <= 1'b0;
			base_prev_reg <= 1'b0;
			bus_clock_reg <= 1'b0;
			bus_tick_reg  <= 1'b0;
		end else begin
			refused_reg   <= bad_range;
			base_prev_reg <= link.base_clock_out;
			bus_tick_reg  <= base_rise && !bus_clock_reg;
			if (base_rise) begin
				bus_clock_reg <= !bus_clock_reg;
			end
		end
	end

	assign cmd_refused = refused_reg;
	assign bus_clock   = bus_clock_reg;
	assign bus_tick    = bus_tick_reg;

endmodule : system_integration

// *** pll_clk_monitor.sv ***
// Checker on the link and selector status of the clock generator pair
`timescale 1ns/1ps
`include "pll_clk_params.svh"

module pll_clk_monitor (
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_b,
	// Link signals
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic               reg_rd,
	input wire logic [`DATA_W-1:0] reg_rdata,
	input wire logic               base_clock_out,
	// Source ticks and selector status
	input wire logic               xtal_tick,
	input wire logic               vco_tick,
	input wire logic               switching,
	input wire logic               vco_active,
	input wire logic               pll_enable
);
	logic [1:0] xcnt; // Crystal edges seen in a changeover
	logic [1:0] vcnt; // VCO edges seen in a changeover
	logic       take;      // Edge the output stage should take
	logic       sw_q;      // Changeover seen one cycle ago
	logic       armed_reg; // Checks start one edge after reset release

	// Only the active source counts, and never during a changeover
	assign take = !switching && (vco_active ? vco_tick : xtal_tick);

	default clocking cb @(posedge clk); endclocking
	// The release edge still finds the design in reset, so it is skipped
	default disable iff (!rst_b || !armed_reg);

	// Arm one edge after release; delayed changeover flag for the counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_reg <= 1'b0;
			sw_q      <= 1'b0;
		end else begin
			armed_reg <= 1'b1;
			sw_q      <= switching;
		end
	end

	// Saturating edge counters, started one cycle into the changeover as the design does
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xcnt <= 2'h0;
			vcnt <= 2'h0;
		end else if (!switching || !sw_q) begin
			xcnt <= 2'h0;
			vcnt <= 2'h0;
		end else begin
			// Count up to the wait figure
			if (xtal_tick && xcnt != 2'h3)
				xcnt <= xcnt + 2'h1;
			if (vco_tick && vcnt != 2'h3)
				vcnt <= vcnt + 2'h1;
		end
	end

	a_edge_toggles: assert property (take |=> base_clock_out != $past(base_clock_out))
		else $error("base clock missed a source edge");
	a_still_between: assert property (!take |=> $stable(base_clock_out))
		else $error("base clock moved without a usable edge");
	a_switch_bounded: assert property ($rose(switching) |-> ##[1:60] !switching)
		else $error("changeover took too long");
	a_xtal_wait: assert property ($fell(switching) |-> xcnt == 2'h3)
		else $error("changeover ended before three crystal edges");
	a_vco_wait: assert property ($fell(switching) |-> vcnt == 2'h3)
		else $error("changeover ended before three vco edges");
	a_select_needs_on: assert property ((reg_rd && reg_addr == `OFS_CONTROL) |=>
		!reg_rdata[`BIT_BCS] || reg_rdata[`BIT_PLL_POWER_ON])
		else $error("select bit read set with power off");
	a_vco_needs_pll: assert property (vco_active |-> pll_enable)
		else $error("vco active while loop disabled");
	a_starts_low: assert property ($rose(rst_b) |-> !base_clock_out)
		else $error("base clock not low after reset");

	// Main scenarios
	c_to_vco: cover property ($fell(switching) && vco_active);
	c_to_xtal: cover property ($fell(switching) && !vco_active);
	c_vco_edge: cover property (take && vco_active);

endmodule : pll_clk_monitor

// *** tb.sv ***
// Self-checking bench joining both ends of the clock generator link
`timescale 1ns/1ps
`include "pll_clk_params.svh"

module tb;
	localparam int XP = 6; // Crystal tick period in clk cycles
	localparam int VP = 4; // VCO tick period in clk cycles
	// Clock, reset, software port
	logic               clk, rst_b, cmd_wr, cmd_rd, cmd_refused, bus_clock, bus_tick;
	logic [`ADDR_W-1:0] cmd_addr;
	logic [`DATA_W-1:0] cmd_wdata, cmd_rdata;
	// Source ticks and device status
	logic               xtal_tick, vco_tick, pll_enable, switching, vco_active, refv;
	logic [1:0]         prescale_exp, range_exp, p, e;
	logic [11:0]        mult_eff, n;
	logic [3:0]         divider_eff, dv;
	logic [14:0]        vco_ratio_num;
	logic [7:0]         linear_range, l;
	logic [10:0]        vco_center_code;
	int                 xc, vc, cycles, bad_count, total_checks;

	pll_link_if pll_link_if_inst ();
	clock_generator clock_generator_inst (.clk(clk), .rst_b(rst_b),
		.link(pll_link_if_inst.device), .xtal_tick(xtal_tick), .vco_tick(vco_tick),
		.pll_enable(pll_enable), .prescale_exp(prescale_exp), .mult_eff(mult_eff),
		.divider_eff(divider_eff), .vco_ratio_num(vco_ratio_num), .range_exp(range_exp),
		.linear_range(linear_range), .vco_center_code(vco_center_code),
		.switching(switching), .vco_active(vco_active));
	system_integration system_integration_inst (.clk(clk), .rst_b(rst_b),
		.link(pll_link_if_inst.host), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .cmd_refused(cmd_refused),
		.bus_clock(bus_clock), .bus_tick(bus_tick));
	pll_clk_monitor mon_inst (.clk(clk), .rst_b(rst_b), .reg_addr(pll_link_if_inst.reg_addr),
		.reg_rd(pll_link_if_inst.reg_rd), .reg_rdata(pll_link_if_inst.reg_rdata),
		.base_clock_out(pll_link_if_inst.base_clock_out), .xtal_tick(xtal_tick),
		.vco_tick(vco_tick), .switching(switching), .vco_active(vco_active),
		.pll_enable(pll_enable));

	// Clock
	always #12.5 clk = ~clk;

	// Source edges as one-cycle pulses at fixed periods
	always @(posedge clk) begin
		xc <= (xc == XP - 1) ? 0 : xc + 1;
		vc <= (vc == VP - 1) ? 0 : vc + 1;
		xtal_tick <= (xc == 0);
		vco_tick <= (vc == 0);
	end

	// Hang guard, far above the expected few hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One-cycle write; keeps the refusal flag of the following cycle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk);
		cmd_wr <= 1'b0;
		#1 refv = cmd_refused;
	endtask : wr

	// One-cycle read, data compared in the cycle after
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clk);
		cmd_rd <= 1'b0;
		#1 check(cmd_rdata, exp);
	endtask : rd

	// Wait out a changeover, bounded, then compare the active source
	task automatic settle(input logic want);
		for (int k = 0; k < 100 && switching !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		check(vco_active, want);
	endtask : settle

	// Cycles between two bus ticks; the first interval may hold a changeover
	task automatic period(input int exp);
		int k;
		repeat (2) begin
			k = 0;
			do begin
				@(posedge clk);
				#1 k++;
			end while (bus_tick !== 1'b1 && k < 400);
		end
		check(16'(k), 16'(exp));
		// Bus clock rises in the same cycle as its tick
		check(bus_clock, 1'b1);
	endtask : period

	// Expected feedback ratio: zero multiplier acts as one
	function automatic logic [14:0] ratio(input logic [11:0] m, input logic [1:0] s);
		return 15'(m == 12'h0 ? 12'h1 : m) << s;
	endfunction : ratio

	// Verdict
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		{clk, rst_b, cmd_wr, cmd_rd, xtal_tick, vco_tick} = 6'h00;
		{cmd_addr, cmd_wdata, xc, vc, cycles, bad_count, total_checks} = '0;
		void'($urandom(10301));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(`OFS_CONTROL, 8'h20);
		// Programming locked while the loop is on
		wr(`OFS_MULT_LOW, 8'haa);
		rd(`OFS_MULT_LOW, 8'h40);
		wr(`OFS_CONTROL, 8'h2e);
		check(refv, 1'b0);
		wr(3'h7, 8'hff);
		wr(`OFS_CONTROL, 8'h03);
		check(refv, 1'b1);
		rd(`OFS_CONTROL, 8'h20);
		period(4 * XP);
		// Interlocks between power and select
		wr(`OFS_CONTROL, 8'h10);
		rd(`OFS_CONTROL, 8'h00);
		wr(`OFS_CONTROL, 8'h10);
		rd(`OFS_CONTROL, 8'h00);
		wr(`OFS_CONTROL, 8'h30);
		rd(`OFS_CONTROL, 8'h20);
		wr(`OFS_CONTROL, 8'h30);
		settle(1'b1);
		period(4 * VP);
		wr(`OFS_CONTROL, 8'h10);
		rd(`OFS_CONTROL, 8'h30);
		wr(`OFS_CONTROL, 8'h20);
		settle(1'b0);
		// Reset in the middle of a changeover
		wr(`OFS_CONTROL, 8'h30);
		repeat (3) @(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(`OFS_CONTROL, 8'h20);
		// Random programming with zero corners, loop off
		wr(`OFS_CONTROL, 8'h00);
		for (int i = 0; i < 8; i++) begin
			n = (i == 0) ? 12'h0 : 12'($urandom);
			dv = (i == 0) ? 4'h0 : 4'($urandom);
			l = (i == 1) ? 8'h0 : 8'($urandom);
			p = 2'($urandom);
			e = 2'($urandom % 3);
			wr(`OFS_MULT_HIGH, {4'h0, n[11:8]});
			wr(`OFS_MULT_LOW, n[7:0]);
			wr(`OFS_DIVIDER, {4'h0, dv});
			wr(`OFS_RANGE, l);
			wr(`OFS_CONTROL, {4'h0, p, e});
			repeat (2) @(posedge clk);
			#1;
			check(mult_eff, n == 12'h0 ? 12'h1 : n);
			check(divider_eff, dv == 4'h0 ? 4'h1 : dv);
			check(vco_ratio_num, ratio(n, p));
			check(vco_center_code, 11'(l) << e);
			check({prescale_exp, range_exp, linear_range}, {p, e, l});
			rd(`OFS_MULT_HIGH, {4'h0, n[11:8]});
		end
		// Zero linear range keeps the loop off and the crystal selected
		wr(`OFS_RANGE, 8'h00);
		wr(`OFS_CONTROL, 8'h20);
		wr(`OFS_CONTROL, 8'h30);
		check(pll_enable, 1'b0);
		rd(`OFS_CONTROL, 8'h20);
		check(vco_active, 1'b0);
		// Crystal still drives the output with the loop disabled
		period(4 * XP);
		complete_run();
	end

endmodule : tb
